// [hdl/nvram_bus_memory_map_decoder.sv]
// Bytewide NV SRAM bus controller with memory-map decode and AXI4-Lite registers.
// Assumes one core clock, core requests on the same clock, SRAM data and pins asynchronous.
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module nvram_bus_memory_map_decoder
  import nvram_map_pkg::*;
(
  // Clock, resets
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic NV_CLEAR,
  // Mode pins
  input wire logic BOOT_MODE,
  input wire logic EXTERNAL_FETCH_FORCE_N,
  // Core access port
  input wire logic ACC_VALID,
  output logic ACC_READY,
  input wire acc_req_type ACC_REQ,
  output logic ACC_DONE,
  output logic [DATA_W-1:0] ACC_RDATA,
  output route_type ACC_ROUTE,
  // Expanded bus hand-off
  output logic EXP_REQ,
  output logic [ADDR_W-1:0] EXP_ADDR,
  // Bytewide SRAM bus
  output logic [MEM_ADDR_W-1:0] MEM_ADDR,
  output logic [DATA_W-1:0] MEM_DQ_O,
  input wire logic [DATA_W-1:0] MEM_DQ_I,
  output logic MEM_DQ_OE,
  output logic MEM_RW_N,
  output logic PRIMARY_RAM_SELECT_N,
  output logic SECONDARY_RAM_SELECT_N,
  // AXI4-Lite slave
  input wire logic [AXI_AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [AXI_AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  localparam int ACC_WAIT_A = ACC_CYCLES;

  typedef struct packed {
    acc_state_type fsm;
    logic [4:0] cnt;
    acc_req_type req;
    route_type route;
    logic [DATA_W-1:0] rdata;
    logic [MEM_ADDR_W-1:0] mem_addr;
    logic dq_oe;
    logic rw_n;
    logic pri_n;
    logic sec_n;
    logic exp_req;
    logic [1:0] ea_sync;
    logic [1:0] boot_sync;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    logic aw_have;
    logic [AXI_AW-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata_bus;
    logic [1:0] rresp;
  } state_type;

  state_type st_q;
  state_type st_d;
  nv_type nv_q;
  nv_type nv_d;
  logic ea_n;
  logic boot;
  logic acc_fire;
  logic wr_fire;
  route_type rt;

  assign ea_n = st_q.ea_sync[1];
  assign boot = st_q.boot_sync[1];
  assign ACC_READY = (st_q.fsm == ST_IDLE);
  assign acc_fire = ACC_VALID && ACC_READY;
  assign wr_fire = st_q.aw_have && st_q.w_have && !st_q.bvalid;
  assign rt = decode_route(ACC_REQ, nv_q, ea_n);

  function automatic logic [31:0] reg_read(input logic [AXI_AW-1:0] a, input nv_type nv, input state_type s);
    logic [31:0] v;
    v = '0;
    case (a)
      CFG_OFFS:
      begin
        v[PART_HI:PART_LO] = nv.part;
        v[RANGE_BIT] = nv.range;
        v[SEC_BIT] = nv.sec;
        v[GUARD_BIT] = nv.guard;
      end
      GUARD_OFFS: v[TA_BIT] = nv.guard;
      MODE_OFFS: v[LOCK_BIT] = nv.lock;
      STAT_OFFS: v[7:0] = {s.route, ~s.ea_sync[1], s.boot_sync[1], s.fsm};
      default: v = '0;
    endcase
    return v;
  endfunction : reg_read

  function automatic logic reg_known(input logic [AXI_AW-1:0] a);
    return a == CFG_OFFS || a == GUARD_OFFS || a == MODE_OFFS || a == STAT_OFFS;
  endfunction : reg_known

  always_comb
  begin
    st_d = st_q;
    nv_d = nv_q;
    // Pin synchronisers
    st_d.ea_sync = {st_q.ea_sync[0], EXTERNAL_FETCH_FORCE_N};
    st_d.boot_sync = {st_q.boot_sync[0], BOOT_MODE};
    st_d.dq_s1 = MEM_DQ_I;
    st_d.dq_s2 = st_q.dq_s1;
    // Access sequencer
    case (st_q.fsm)
      ST_IDLE:
      begin
        if (acc_fire)
        begin
          st_d.req = ACC_REQ;
          st_d.route = rt;
          if (rt.pri || rt.sec)
          begin
            st_d.mem_addr = ACC_REQ.addr[MEM_ADDR_W-1:0];
            st_d.rw_n = !ACC_REQ.write;
            st_d.dq_oe = ACC_REQ.write;
            st_d.pri_n = !rt.pri;
            st_d.sec_n = !rt.sec;
            st_d.cnt = ACC_LAST;
            st_d.fsm = ST_WAIT;
          end
          else
          begin
            st_d.exp_req = rt.exp;
            st_d.fsm = ST_DONE;
          end
        end
      end
      ST_WAIT:
      begin
        if (st_q.cnt == '0)
        begin
          // Data was read through two flops, so the byte taken left the pins two cycles before the count ended
          st_d.rdata = st_q.dq_s2;
          st_d.pri_n = 1'b1;
          st_d.sec_n = 1'b1;
          st_d.dq_oe = 1'b0;
          st_d.rw_n = 1'b1;
          st_d.fsm = ST_DONE;
        end
        else
          st_d.cnt = st_q.cnt - 5'h1;
      end
      ST_DONE:
      begin
        st_d.exp_req = 1'b0;
        st_d.fsm = ST_IDLE;
      end
      default: st_d.fsm = ST_IDLE;
    endcase
    // AXI write channels, taken in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      st_d.aw_have = 1'b1;
      st_d.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      st_d.w_have = 1'b1;
      st_d.w_data = S_AXI_WDATA;
      st_d.w_strb = S_AXI_WSTRB;
    end
    if (wr_fire)
    begin
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = reg_known(st_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (st_q.w_strb[0])
      begin
        case (st_q.aw_addr)
          CFG_OFFS:
          begin
            if (nv_q.guard)
              nv_d.part = st_q.w_data[PART_HI:PART_LO];
            if (boot)
              nv_d.range = st_q.w_data[RANGE_BIT];
            nv_d.sec = st_q.w_data[SEC_BIT];
            // Guard bit in this register is read-only on purpose
          end
          GUARD_OFFS: nv_d.guard = st_q.w_data[TA_BIT];
          MODE_OFFS:
          begin
            // Lock only set by the loader, never by application code
            if (boot)
              nv_d.lock = st_q.w_data[LOCK_BIT];
          end
          default: nv_d = nv_q;
        endcase
      end
    end
    if (st_q.bvalid && S_AXI_BREADY)
      st_d.bvalid = 1'b0;
    // AXI read channel
    if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      st_d.rvalid = 1'b1;
      st_d.rdata_bus = reg_read(S_AXI_ARADDR, nv_q, st_q);
      st_d.rresp = reg_known(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (st_q.rvalid && S_AXI_RREADY)
      st_d.rvalid = 1'b0;
  end

  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      st_q <= '0;
      st_q.fsm <= ST_IDLE;
      st_q.rw_n <= 1'b1;
      st_q.pri_n <= 1'b1;
      st_q.sec_n <= 1'b1;
      st_q.ea_sync <= 2'h3;
    end
    else
      st_q <= st_d;
  end

  // Battery-backed settings ignore core reset so wrong values persist too
  always_ff @(posedge REF_CLK or posedge NV_CLEAR)
  begin
    if (NV_CLEAR)
      nv_q <= nv_type'(NV_CLEAR_VAL[7:0]);
    else
      nv_q <= nv_d;
  end

  assign ACC_DONE = (st_q.fsm == ST_DONE);
  assign ACC_RDATA = st_q.rdata;
  assign ACC_ROUTE = st_q.route;
  assign EXP_REQ = st_q.exp_req;
  assign EXP_ADDR = st_q.req.addr;
  assign MEM_ADDR = st_q.mem_addr;
  assign MEM_DQ_O = st_q.req.wdata;
  assign MEM_DQ_OE = st_q.dq_oe;
  assign MEM_RW_N = st_q.rw_n;
  assign PRIMARY_RAM_SELECT_N = st_q.pri_n;
  assign SECONDARY_RAM_SELECT_N = st_q.sec_n;
  assign S_AXI_AWREADY = !st_q.aw_have && !st_q.bvalid;
  assign S_AXI_WREADY = !st_q.w_have && !st_q.bvalid;
  assign S_AXI_BVALID = st_q.bvalid;
  assign S_AXI_BRESP = st_q.bresp;
  assign S_AXI_ARREADY = !st_q.rvalid;
  assign S_AXI_RVALID = st_q.rvalid;
  assign S_AXI_RDATA = st_q.rdata_bus;
  assign S_AXI_RRESP = st_q.rresp;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET || NV_CLEAR);

  AST_RANGE_LIMIT: assert property ((st_q.fsm == ST_WAIT) |-> st_q.req.addr < range_limit(nv_q.range))
    else $error("bytewide access above range");
  AST_RANGE_LOCKED: assert property ((wr_fire && !boot) |=> nv_q.range == $past(nv_q.range))
    else $error("range changed outside bootstrap");
  AST_PART_GUARD: assert property ((wr_fire && !nv_q.guard) |=> $stable(nv_q.part))
    else $error("partition written while guarded");
  AST_EA_FORCE: assert property ((acc_fire && !ea_n && !nv_q.lock && !ACC_REQ.loader) |=> st_q.route.exp)
    else $error("low access pin did not force expanded bus");
  AST_LOCK_FETCH: assert property ((acc_fire && ACC_REQ.fetch && nv_q.lock) |=> !st_q.route.exp && !EXP_REQ)
    else $error("fetch reached expanded bus under lock");
  AST_LOADER_READ: assert property ((acc_fire && ACC_REQ.loader && !ACC_REQ.write && nv_q.lock)
    |=> st_q.route.blocked && PRIMARY_RAM_SELECT_N && SECONDARY_RAM_SELECT_N)
    else $error("loader read not refused under lock");
  AST_SEC_DATA: assert property ((acc_fire && !ACC_REQ.fetch && !ACC_REQ.loader && nv_q.sec && (ea_n || nv_q.lock)
    && ACC_REQ.addr < range_limit(nv_q.range)) |=> !SECONDARY_RAM_SELECT_N && PRIMARY_RAM_SELECT_N)
    else $error("data access missed second RAM");
  AST_FETCH_PRI: assert property ((acc_fire && ACC_REQ.fetch && !ACC_REQ.loader && (ea_n || nv_q.lock)
    && ACC_REQ.addr < part_bound(nv_q.part, nv_q.lock) && ACC_REQ.addr < range_limit(nv_q.range))
    |=> !PRIMARY_RAM_SELECT_N)
    else $error("fetch below partition not on first RAM");
  AST_ACC_TIME: assert property ($fell(PRIMARY_RAM_SELECT_N) |-> ##[ACC_WAIT_A:ACC_WAIT_A] ACC_DONE)
    else $error("SRAM access length wrong");

  CV_SEC: cover property (acc_fire ##1 !SECONDARY_RAM_SELECT_N);
  CV_BLOCK: cover property (acc_fire ##1 st_q.route.blocked);
  CV_EXP: cover property (EXP_REQ ##1 ACC_DONE);
  CV_WRITE: cover property (wr_fire ##1 S_AXI_BVALID);

endmodule : nvram_bus_memory_map_decoder
`default_nettype wire

// [hdl/nvram_map_pkg.sv]
// Constants, types and decode functions for the bytewide memory-map decoder.
// Assumes a single 250 MHz core clock domain and 16-bit logical addresses.
package nvram_map_pkg;

  localparam int ADDR_W = 16;
  localparam int MEM_ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int AXI_AW = 4;

  // Register byte offsets
  localparam logic [AXI_AW-1:0] CFG_OFFS = 4'h0;
  localparam logic [AXI_AW-1:0] GUARD_OFFS = 4'h4;
  localparam logic [AXI_AW-1:0] MODE_OFFS = 4'h8;
  localparam logic [AXI_AW-1:0] STAT_OFFS = 4'hC;

  // Field positions of memory_config_reg; LOCK_BIT and TA_BIT are bit 0 of the mode and guard registers
  localparam int PART_HI = 7;
  localparam int PART_LO = 4;
  localparam int RANGE_BIT = 3;
  localparam int SEC_BIT = 2;
  localparam int GUARD_BIT = 1;
  localparam int LOCK_BIT = 0;
  localparam int TA_BIT = 0;

  // Decode values
  localparam logic [3:0] PART_ZERO = 4'h0;
  localparam logic [3:0] PART_TOP = 4'hF;
  localparam logic [10:0] SEG_ZERO = 11'h000;
  localparam logic [ADDR_W-1:0] TOP_BOUND = 16'h8000;
  localparam logic [ADDR_W-1:0] LIMIT_8K = 16'h2000;
  localparam logic [ADDR_W-1:0] LIMIT_32K = 16'h8000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] NV_CLEAR_VAL = 32'h0000_0000;

  // SRAM access time and its count of core clocks, rounded up
  localparam int ACC_TIME_NS = 70;
  localparam int CLK_PERIOD_NS = 4;
  localparam int ACC_CYCLES = (ACC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] ACC_LAST = 5'(ACC_CYCLES - 1);

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_DONE = 2'h3
  } acc_state_type;

  typedef struct packed {
    logic fetch;
    logic loader;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } acc_req_type;

  typedef struct packed {
    logic pri;
    logic sec;
    logic exp;
    logic blocked;
  } route_type;

  typedef struct packed {
    logic [3:0] part;
    logic range;
    logic sec;
    logic guard;
    logic lock;
  } nv_type;

  function automatic logic [ADDR_W-1:0] range_limit(input logic range);
    return range ? LIMIT_32K : LIMIT_8K;
  endfunction : range_limit

  function automatic logic [ADDR_W-1:0] part_bound(input logic [3:0] part, input logic lock);
    if ((lock && part == PART_ZERO) || part == PART_TOP)
      return TOP_BOUND;
    return {1'b0, part, SEG_ZERO};
  endfunction : part_bound

  function automatic route_type decode_route(input acc_req_type req, input nv_type nv, input logic ea_n);
    route_type r;
    logic [ADDR_W-1:0] lim;
    logic [ADDR_W-1:0] bound;
    r = '0;
    lim = range_limit(nv.range);
    bound = part_bound(nv.part, nv.lock);
    if (req.loader && !req.write && nv.lock)
      r.blocked = 1'b1;
    else if (!ea_n && !nv.lock)
      r.exp = 1'b1;
    else if (req.fetch)
    begin
      if (req.addr < bound && req.addr < lim)
        r.pri = 1'b1;
      else if (nv.lock)
        r.blocked = 1'b1;
      else
        r.exp = 1'b1;
    end
    else if (nv.sec && req.addr < lim)
      r.sec = 1'b1;
    else if (req.addr >= bound && req.addr < lim)
      r.pri = 1'b1;
    else
      r.exp = 1'b1;
    return r;
  endfunction : decode_route

endpackage : nvram_map_pkg

// [verif/nvsram_model.sv]
// Model of one byte-wide battery-backed SRAM chip behind one chip enable.
// Assumes select, strobe and address change only on the core clock edge.
`timescale 1ns/100ps
`default_nettype none
module nvsram_model
(
  // Clock
  input wire logic clk,
  // Memory bus
  input wire logic sel_n,
  input wire logic rw_n,
  input wire logic oe,
  input wire logic [14:0] addr,
  input wire logic [7:0] din,
  output logic [7:0] dout
);
  logic [7:0] mem [0:32767];

  // Contents start as the low address byte, so reads are predictable
  initial
  begin
    for (int i = 0; i < 32768; i++)
      mem[i] = i[7:0];
  end

  // A released bus toggles each cycle, so a stale byte never looks valid
  always @(posedge clk)
  begin
    if (!sel_n && !rw_n && oe)
      mem[addr] <= din;
    if (!sel_n && rw_n)
      dout <= mem[addr];
    else
      dout <= ~dout;
  end
endmodule : nvsram_model
`default_nettype wire

// [verif/nvram_bus_memory_map_decoder_tb.sv]
// Self-checking bench: register writes over AXI4-Lite, then core accesses.
// Assumes one SRAM model on each chip enable.
`timescale 1ns/100ps
`default_nettype none
module nvram_bus_memory_map_decoder_tb
  import nvram_map_pkg::*;
;
  localparam logic [3:0] PRI = 4'h8;
  localparam logic [3:0] SEC = 4'h4;
  localparam logic [3:0] EXP = 4'h2;
  localparam logic [3:0] BLK = 4'h1;
  logic REF_CLK, RESET, NV_CLEAR, BOOT_MODE, EXTERNAL_FETCH_FORCE_N, ACC_VALID, ACC_READY, ACC_DONE;
  logic EXP_REQ, MEM_DQ_OE, MEM_RW_N, PRIMARY_RAM_SELECT_N, SECONDARY_RAM_SELECT_N;
  acc_req_type ACC_REQ;
  route_type ACC_ROUTE;
  logic [7:0] ACC_RDATA, MEM_DQ_O, MEM_DQ_I, dq_pri, dq_sec;
  logic [15:0] EXP_ADDR, b;
  logic [14:0] MEM_ADDR;
  logic [3:0] S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WSTRB;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  int fail_count, n_compared;

  assign MEM_DQ_I = !PRIMARY_RAM_SELECT_N ? dq_pri : dq_sec;

  nvram_bus_memory_map_decoder dut_u (.REF_CLK, .RESET, .NV_CLEAR, .BOOT_MODE, .EXTERNAL_FETCH_FORCE_N,
    .ACC_VALID, .ACC_READY, .ACC_REQ, .ACC_DONE, .ACC_RDATA, .ACC_ROUTE, .EXP_REQ, .EXP_ADDR, .MEM_ADDR,
    .MEM_DQ_O, .MEM_DQ_I, .MEM_DQ_OE, .MEM_RW_N, .PRIMARY_RAM_SELECT_N, .SECONDARY_RAM_SELECT_N,
    .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
  nvsram_model pri_u (.clk(REF_CLK), .sel_n(PRIMARY_RAM_SELECT_N), .rw_n(MEM_RW_N), .oe(MEM_DQ_OE),
    .addr(MEM_ADDR), .din(MEM_DQ_O), .dout(dq_pri));
  nvsram_model sec_u (.clk(REF_CLK), .sel_n(SECONDARY_RAM_SELECT_N), .rw_n(MEM_RW_N), .oe(MEM_DQ_OE),
    .addr(MEM_ADDR), .din(MEM_DQ_O), .dout(dq_sec));

  initial
  begin
    REF_CLK = 1'b0;
    forever
      #2 REF_CLK = ~REF_CLK;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge REF_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h000000, d};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    n = 0;
    do
    begin
      @(posedge REF_CLK);
      n++;
      if (S_AXI_AWREADY === 1'b1)
        S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY === 1'b1)
        S_AXI_WVALID <= 1'b0;
    end
    while (S_AXI_BVALID !== 1'b1 && n < 50);
    S_AXI_BREADY <= 1'b0;
    if (n >= 50)
    begin
      fail_count++;
      $display("Error %0t: write response hang", $time);
    end
    chk(S_AXI_BRESP, er, "bresp");
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, input logic [7:0] e);
    int n;
    @(posedge REF_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    n = 0;
    do
    begin
      @(posedge REF_CLK);
      n++;
      if (S_AXI_ARREADY === 1'b1)
        S_AXI_ARVALID <= 1'b0;
    end
    while (S_AXI_RVALID !== 1'b1 && n < 50);
    S_AXI_RREADY <= 1'b0;
    if (n >= 50)
    begin
      fail_count++;
      $display("Error %0t: read response hang", $time);
    end
    chk(S_AXI_RDATA, {24'h000000, e}, "rdata");
  endtask : axi_rd

  // Core access; read data is checked only when the byte comes from a RAM
  task automatic acc(input logic f, input logic l, input logic w, input logic [15:0] a, input logic [3:0] er,
    input logic [7:0] ed);
    int n;
    @(posedge REF_CLK);
    ACC_REQ <= '{f, l, w, a, ed};
    ACC_VALID <= 1'b1;
    n = 0;
    do
    begin
      @(posedge REF_CLK);
      n++;
    end
    while (ACC_READY !== 1'b1 && n < 40);
    ACC_VALID <= 1'b0;
    do
    begin
      @(posedge REF_CLK);
      n++;
    end
    while (ACC_DONE !== 1'b1 && n < 80);
    if (n >= 80)
    begin
      fail_count++;
      $display("Error %0t: access hang", $time);
    end
    chk(ACC_ROUTE, er, "route");
    chk(EXP_REQ, er == EXP, "xreq");
    if (er == EXP)
      chk(EXP_ADDR, a, "xaddr");
    if (!w && (er == PRI || er == SEC))
      chk(ACC_RDATA, ed, "byte");
  endtask : acc

  task automatic pins(input logic bm, input logic ea);
    @(posedge REF_CLK);
    BOOT_MODE <= bm;
    EXTERNAL_FETCH_FORCE_N <= ea;
    repeat (4) @(posedge REF_CLK);
  endtask : pins

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  // About 1200 cycles are expected; the limit leaves ample margin
  initial
  begin
    #100000;
    fail_count++;
    $display("Error %0t: timeout", $time);
    summarize();
  end

  initial
  begin
    {RESET, NV_CLEAR, EXTERNAL_FETCH_FORCE_N} = 3'b111;
    {BOOT_MODE, ACC_VALID, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    ACC_REQ = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
    S_AXI_WSTRB = 4'hF;
    repeat (12) @(posedge REF_CLK);
    RESET <= 1'b0;
    NV_CLEAR <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    axi_rd(CFG_OFFS, 8'h00);
    axi_wr(4'h2, 8'hFF, RESP_SLVERR);
    pins(1'b1, 1'b1);
    axi_wr(GUARD_OFFS, 8'h01, RESP_OKAY);
    axi_wr(CFG_OFFS, 8'h08, RESP_OKAY);
    axi_rd(CFG_OFFS, 8'h0A);
    $display("test registers done");
    for (int p = 1; p < 16; p++)
    begin
      b = (p == 15) ? 16'h8000 : 16'(p) << 11;
      axi_wr(CFG_OFFS, {p[3:0], 4'h8}, RESP_OKAY);
      acc(1'b1, 1'b0, 1'b0, b - 16'h0001, PRI, 8'hFF);
      acc(1'b1, 1'b0, 1'b0, b, EXP, 8'h00);
      acc(1'b0, 1'b0, 1'b0, b, b < 16'h8000 ? PRI : EXP, 8'h00);
      acc(1'b0, 1'b0, 1'b0, b - 16'h0001, EXP, 8'h00);
    end
    $display("test partition done");
    axi_wr(CFG_OFFS, 8'h38, RESP_OKAY);
    acc(1'b0, 1'b0, 1'b1, 16'h7FFF, PRI, 8'hA5);
    acc(1'b0, 1'b0, 1'b0, 16'h7FFF, PRI, 8'hA5);
    axi_wr(CFG_OFFS, 8'h3C, RESP_OKAY);
    acc(1'b0, 1'b0, 1'b1, 16'h0000, SEC, 8'h5A);
    acc(1'b0, 1'b0, 1'b0, 16'h0000, SEC, 8'h5A);
    acc(1'b0, 1'b0, 1'b0, 16'h7FFF, SEC, 8'hFF);
    acc(1'b0, 1'b0, 1'b0, 16'h8000, EXP, 8'h00);
    acc(1'b1, 1'b0, 1'b0, 16'h0000, PRI, 8'h00);
    axi_wr(CFG_OFFS, 8'h50, RESP_OKAY);
    acc(1'b0, 1'b0, 1'b0, 16'h1FFF, EXP, 8'h00);
    acc(1'b1, 1'b0, 1'b0, 16'h1FFF, PRI, 8'hFF);
    acc(1'b1, 1'b0, 1'b0, 16'h2000, EXP, 8'h00);
    $display("test routing done");
    pins(1'b0, 1'b1);
    axi_wr(CFG_OFFS, 8'h18, RESP_OKAY);
    axi_rd(CFG_OFFS, 8'h12);
    axi_wr(GUARD_OFFS, 8'h00, RESP_OKAY);
    axi_wr(CFG_OFFS, 8'h70, RESP_OKAY);
    axi_rd(CFG_OFFS, 8'h10);
    pins(1'b0, 1'b0);
    acc(1'b1, 1'b0, 1'b0, 16'h0000, EXP, 8'h00);
    acc(1'b0, 1'b0, 1'b0, 16'h1000, EXP, 8'h00);
    $display("test application done");
    pins(1'b1, 1'b0);
    axi_wr(MODE_OFFS, 8'h01, RESP_OKAY);
    axi_wr(GUARD_OFFS, 8'h01, RESP_OKAY);
    axi_wr(CFG_OFFS, 8'h08, RESP_OKAY);
    acc(1'b1, 1'b0, 1'b0, 16'h7FFE, PRI, 8'hFE);
    acc(1'b0, 1'b0, 1'b0, 16'h0000, EXP, 8'h00);
    acc(1'b0, 1'b1, 1'b0, 16'h0000, BLK, 8'h00);
    acc(1'b1, 1'b0, 1'b0, 16'h8000, BLK, 8'h00);
    pins(1'b1, 1'b1);
    acc(1'b1, 1'b0, 1'b0, 16'h8000, BLK, 8'h00);
    @(posedge REF_CLK);
    RESET <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    RESET <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    axi_rd(CFG_OFFS, 8'h0A);
    axi_rd(MODE_OFFS, 8'h01);
    axi_rd(STAT_OFFS, 8'h04);
    $display("test lock done");
    summarize();
  end
endmodule : nvram_bus_memory_map_decoder_tb
`default_nettype wire
